// file: include/acs_regs.vh
// Register indices, field positions and reset values of the converter selection block.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define ACS_IDX_DATA_LOW     8'h78
`define ACS_IDX_DATA_HIGH    8'h79
`define ACS_IDX_CTRL_A       8'h7A
`define ACS_IDX_CTRL_B       8'h7B
`define ACS_IDX_INPUT_SEL    8'h7C
`define ACS_IDX_INT_STATUS   8'h80
`define ACS_IDX_INT_MASK     8'h81

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACS_SEL_REF_HI       7
`define ACS_SEL_REF_LO       6
`define ACS_SEL_LEFT_ALIGN   5
`define ACS_CTLA_ENABLE      7
`define ACS_CTLA_START       6
`define ACS_CTLA_AUTO_TRIG   5
`define ACS_CTLA_DONE        4
`define ACS_CTLB_CMP_MUX     6
`define ACS_CTLB_CODE_HIGH   3
`define ACS_INT_DONE         0
`define ACS_INT_TRIG         1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define ACS_RST_INPUT_SEL    8'h00
`define ACS_RST_CTRL_A       8'h00
`define ACS_RST_CTRL_B       8'h00
`define ACS_CTLB_WR_MASK     8'h4F
`define ACS_INT_BITS_MASK    2'h3

// ----------------------------------------------------------------
// Reference selection codes and gain codes
// ----------------------------------------------------------------
`define ACS_REF_EXT_PIN      2'h0
`define ACS_REF_SUPPLY       2'h1
`define ACS_REF_INT_1V1      2'h2
`define ACS_REF_INT_2V56     2'h3
`define ACS_GAIN_1X          2'h0
`define ACS_GAIN_10X         2'h1
`define ACS_GAIN_200X        2'h2

`define ACS_RESP_OKAY        2'h0
`define ACS_RESP_SLVERR      2'h2

`endif

// file: logic/acs_code_decode.v
// Decoder of the 6-bit channel/gain code into input routing.
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_code_decode (
  input  wire [5:0] code,
  output reg        code_valid,
  output reg        single_ended,
  output reg  [3:0] se_channel,
  output reg        sel_bandgap,
  output reg        sel_ground,
  output reg        differential,
  output reg  [3:0] pos_channel,
  output reg  [3:0] neg_channel,
  output reg  [1:0] gain
);

  always @* begin
    code_valid   = 1'b1;
    single_ended = 1'b0;
    se_channel   = 4'h0;
    sel_bandgap  = 1'b0;
    sel_ground   = 1'b0;
    differential = 1'b0;
    pos_channel  = 4'h0;
    neg_channel  = 4'h0;
    gain         = `ACS_GAIN_1X;
    case (code[5:3])
      3'h0: begin
        single_ended = 1'b1;
        se_channel   = {1'b0, code[2:0]};
      end
      3'h1: begin
        differential = 1'b1;
        pos_channel  = {2'h0, code[2], code[0]};
        neg_channel  = {2'h0, code[2], 1'b0};
        gain         = code[1] ? `ACS_GAIN_200X : `ACS_GAIN_10X;
      end
      3'h2: begin
        differential = 1'b1;
        pos_channel  = {1'b0, code[2:0]};
        neg_channel  = 4'h1;
      end
      3'h3: begin
        if (code[2:0] == 3'h6) begin
          sel_bandgap = 1'b1;
        end else if (code[2:0] == 3'h7) begin
          sel_ground = 1'b1;
        end else begin
          differential = 1'b1;
          pos_channel  = {1'b0, code[2:0]};
          neg_channel  = 4'h2;
        end
      end
      3'h4: begin
        single_ended = 1'b1;
        se_channel   = {1'b1, code[2:0]};
      end
      default: begin
        code_valid = 1'b0;
      end
    endcase
  end

endmodule // acs_code_decode

// file: logic/acs_top.v
// AXI4-Lite register block selecting reference, alignment and input of a 10-bit converter.
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  trigger_in,
  input  wire        core_done,
  input  wire [9:0]  core_result,
  output reg         conv_start,
  output wire        conv_busy,
  output reg         converter_enable,
  output reg  [2:0]  prescaler_select,
  output reg         comparator_mux_enable,
  output reg  [1:0]  reference_select,
  output reg         internal_ref_enable,
  output reg         code_valid,
  output reg         single_ended,
  output reg  [3:0]  se_channel,
  output reg         sel_bandgap,
  output reg         sel_ground,
  output reg         differential,
  output reg  [3:0]  pos_channel,
  output reg  [3:0]  neg_channel,
  output reg  [1:0]  gain,
  output wire        irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Sticky flag update; a set in the same cycle as a clear wins.
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg        aw_held_r;
  reg [7:0]  aw_idx_r;
  reg        w_held_r;
  reg [7:0]  w_data_r;
  reg        w_strb_r;
  reg [1:0]  sw_ref_r;
  reg        left_align_r;
  reg [4:0]  sw_code_low_r;
  reg        sw_code_high_r;
  reg [2:0]  trig_src_r;
  reg        auto_trig_r;
  reg        done_flag_r;
  reg        busy_r;
  reg [9:0]  result_r;
  reg [1:0]  int_status_r;
  reg [1:0]  int_mask_r;
  reg        trig_prev_r;
  reg [5:0]  act_code_r;

  wire       wr_fire;
  wire       rd_fire;
  wire       wr_en;
  wire       trig_sel;
  wire       trig_rise;
  wire       sw_start;
  wire       start_now;
  wire       hold_sel;
  wire [1:0] ref_nxt;
  wire [5:0] code_nxt;
  wire       dec_valid;
  wire       dec_se;
  wire [3:0] dec_se_ch;
  wire       dec_bg;
  wire       dec_gnd;
  wire       dec_diff;
  wire [3:0] dec_pos;
  wire [3:0] dec_neg;
  wire [1:0] dec_gain;
  reg  [7:0] rd_byte;
  reg        rd_hit;

  // ----------------------------------------------------------------
  // Write channel handshake
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign wr_fire       = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_en         = wr_fire & w_strb_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      aw_idx_r     <= 8'h00;
      w_held_r     <= 1'b0;
      w_data_r     <= 8'h00;
      w_strb_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (aw_idx_r)
          `ACS_IDX_DATA_LOW, `ACS_IDX_DATA_HIGH, `ACS_IDX_CTRL_A, `ACS_IDX_CTRL_B,
          `ACS_IDX_INPUT_SEL, `ACS_IDX_INT_STATUS, `ACS_IDX_INT_MASK: begin
            s_axi_bresp <= `ACS_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `ACS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // selected trigger edge
  assign trig_sel  = trigger_in[trig_src_r];
  assign trig_rise = trig_sel & ~trig_prev_r;
  assign sw_start  = wr_en && (aw_idx_r == `ACS_IDX_CTRL_A) && w_data_r[`ACS_CTLA_START];
  assign start_now = converter_enable & ~busy_r & (sw_start | (auto_trig_r & trig_rise));
  assign conv_busy = busy_r;

  assign hold_sel = busy_r & ~core_done;
  assign ref_nxt  = hold_sel ? reference_select : sw_ref_r;
  assign code_nxt = hold_sel ? act_code_r : {sw_code_high_r, sw_code_low_r};

  acs_code_decode u_decode (
    .code         (code_nxt),
    .code_valid   (dec_valid),
    .single_ended (dec_se),
    .se_channel   (dec_se_ch),
    .sel_bandgap  (dec_bg),
    .sel_ground   (dec_gnd),
    .differential (dec_diff),
    .pos_channel  (dec_pos),
    .neg_channel  (dec_neg),
    .gain         (dec_gain)
  );

  // ----------------------------------------------------------------
  // Registers and converter state
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_ref_r              <= 2'h0;
      left_align_r          <= 1'b0;
      sw_code_low_r         <= 5'h00;
      sw_code_high_r        <= 1'b0;
      trig_src_r            <= 3'h0;
      comparator_mux_enable <= 1'b0;
      auto_trig_r           <= 1'b0;
      converter_enable      <= 1'b0;
      prescaler_select      <= 3'h0;
      done_flag_r           <= 1'b0;
      busy_r                <= 1'b0;
      result_r              <= 10'h000;
      int_status_r          <= 2'h0;
      int_mask_r            <= 2'h0;
      trig_prev_r           <= 1'b0;
      conv_start            <= 1'b0;
      act_code_r            <= 6'h00;
      reference_select      <= `ACS_REF_EXT_PIN;
      internal_ref_enable   <= 1'b0;
      code_valid            <= 1'b1;
      single_ended          <= 1'b1;
      se_channel            <= 4'h0;
      sel_bandgap           <= 1'b0;
      sel_ground            <= 1'b0;
      differential          <= 1'b0;
      pos_channel           <= 4'h0;
      neg_channel           <= 4'h0;
      gain                  <= `ACS_GAIN_1X;
    end else begin
      trig_prev_r <= trig_sel;
      conv_start  <= start_now;
      if (wr_en && aw_idx_r == `ACS_IDX_INPUT_SEL) begin
        sw_ref_r      <= w_data_r[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO];
        left_align_r  <= w_data_r[`ACS_SEL_LEFT_ALIGN];
        sw_code_low_r <= w_data_r[4:0];
      end
      if (wr_en && aw_idx_r == `ACS_IDX_CTRL_B) begin
        comparator_mux_enable <= w_data_r[`ACS_CTLB_CMP_MUX];
        sw_code_high_r        <= w_data_r[`ACS_CTLB_CODE_HIGH];
        trig_src_r            <= w_data_r[2:0];
      end
      if (wr_en && aw_idx_r == `ACS_IDX_CTRL_A) begin
        converter_enable <= w_data_r[`ACS_CTLA_ENABLE];
        auto_trig_r      <= w_data_r[`ACS_CTLA_AUTO_TRIG];
        prescaler_select <= w_data_r[2:0];
      end
      if (wr_en && aw_idx_r == `ACS_IDX_INT_MASK) begin
        int_mask_r <= w_data_r[1:0] & `ACS_INT_BITS_MASK;
      end
      // Turning the converter off abandons a running conversion.
      if (start_now) begin
        busy_r <= 1'b1;
      end else if (core_done || !converter_enable) begin
        busy_r <= 1'b0;
      end
      if (busy_r && core_done) begin
        result_r <= core_result;
      end
      done_flag_r <= flag_next(done_flag_r, busy_r & core_done,
                               wr_en && aw_idx_r == `ACS_IDX_CTRL_A &&
                               w_data_r[`ACS_CTLA_DONE]);
      int_status_r[`ACS_INT_DONE] <= flag_next(int_status_r[`ACS_INT_DONE],
                                    busy_r & core_done,
                                    wr_en && aw_idx_r == `ACS_IDX_INT_STATUS &&
                                    w_data_r[`ACS_INT_DONE]);
      int_status_r[`ACS_INT_TRIG] <= flag_next(int_status_r[`ACS_INT_TRIG],
                                    start_now & ~sw_start,
                                    wr_en && aw_idx_r == `ACS_IDX_INT_STATUS &&
                                    w_data_r[`ACS_INT_TRIG]);
      act_code_r          <= code_nxt;
      reference_select    <= ref_nxt;
      internal_ref_enable <= (ref_nxt == `ACS_REF_INT_1V1) || (ref_nxt == `ACS_REF_INT_2V56);
      code_valid          <= dec_valid;
      single_ended        <= dec_se;
      se_channel          <= dec_se_ch;
      sel_bandgap         <= dec_bg;
      sel_ground          <= dec_gnd;
      differential        <= dec_diff;
      pos_channel         <= dec_pos;
      neg_channel         <= dec_neg;
      gain                <= dec_gain;
    end
  end

  assign irq = |(int_status_r & int_mask_r);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid & ~s_axi_rvalid;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr[9:2])
      `ACS_IDX_DATA_LOW: begin
        rd_byte = left_align_r ? {result_r[1:0], 6'h00} : result_r[7:0];
      end
      `ACS_IDX_DATA_HIGH: begin
        rd_byte = left_align_r ? result_r[9:2] : {6'h00, result_r[9:8]};
      end
      `ACS_IDX_CTRL_A: begin
        rd_byte = {converter_enable, busy_r, auto_trig_r, done_flag_r,
                   1'b0, prescaler_select};
      end
      `ACS_IDX_CTRL_B: begin
        rd_byte = {1'b0, comparator_mux_enable, 2'h0, sw_code_high_r, trig_src_r}
                  & `ACS_CTLB_WR_MASK;
      end
      `ACS_IDX_INPUT_SEL: begin
        rd_byte = {sw_ref_r, left_align_r, sw_code_low_r};
      end
      `ACS_IDX_INT_STATUS: begin
        rd_byte = {6'h00, int_status_r};
      end
      `ACS_IDX_INT_MASK: begin
        rd_byte = {6'h00, int_mask_r};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ACS_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // acs_top

// file: tb/acs_core_model.sv
// Behavioural converter core that answers each start pulse after a set delay.
`timescale 1ns/1ps
module acs_core_model (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       conv_start,
  input  logic [7:0] dly,
  input  logic [9:0] result,
  output logic       core_done,
  output logic [9:0] core_result
);
  logic [7:0] cnt_r;
  // Outside the done pulse the result lines toggle, so no stale value can pass as valid.
  always @(posedge aclk) begin
    core_done <= 1'h0;
    core_result <= ~core_result;
    if (!aresetn) begin
      cnt_r <= 8'h00;
      core_result <= 10'h000;
    end else if (conv_start) begin
      cnt_r <= dly;
    end else if (cnt_r == 8'h01) begin
      cnt_r <= 8'h00;
      core_done <= 1'h1;
      core_result <= result;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // acs_core_model

// file: tb/acs_chk_chk.sv
// Concurrent checks on the ports of the converter selection block.
`timescale 1ns/1ps
module acs_chk (
  input logic       aclk,
  input logic       aresetn,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic       core_done,
  input logic       conv_start,
  input logic       conv_busy,
  input logic [1:0] reference_select,
  input logic       internal_ref_enable,
  input logic       code_valid,
  input logic       single_ended,
  input logic [3:0] se_channel,
  input logic       sel_bandgap,
  input logic       sel_ground,
  input logic       differential,
  input logic [3:0] pos_channel,
  input logic [3:0] neg_channel,
  input logic [1:0] gain
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence busy_run;
    conv_busy && !core_done ##1 conv_busy && !core_done;
  endsequence
  sequence done_seen;
    conv_busy && core_done;
  endsequence
  chk_sel_frozen: assert property (
    busy_run |=> $stable({reference_select, se_channel, pos_channel, neg_channel, gain}))
    else $error("selection changed during a conversion");
  chk_done_idle: assert property (done_seen |=> !conv_busy)
    else $error("busy stayed up after completion");
  chk_start_once: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  chk_start_busy: assert property (conv_start |-> ##[0:1] conv_busy)
    else $error("start without busy");
  chk_ref_internal: assert property (internal_ref_enable == reference_select[1])
    else $error("internal reference enable wrong");
  chk_amp_pairs: assert property (
    differential && gain != 2'h0 |-> !neg_channel[0] && neg_channel[3:2] == 2'h0
      && pos_channel[3:1] == neg_channel[3:1])
    else $error("amplified pair wrong");
  chk_unity_pairs: assert property (
    differential && gain == 2'h0 |-> (neg_channel == 4'h1 && pos_channel <= 4'h7)
      || (neg_channel == 4'h2 && pos_channel <= 4'h5))
    else $error("unity pair wrong");
  chk_one_route: assert property (
    code_valid |-> $onehot({single_ended, sel_bandgap, sel_ground, differential}))
    else $error("more than one route selected");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule // acs_chk

bind acs_top acs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .core_done(core_done),
  .conv_start(conv_start), .conv_busy(conv_busy), .reference_select(reference_select),
  .internal_ref_enable(internal_ref_enable), .code_valid(code_valid),
  .single_ended(single_ended), .se_channel(se_channel), .sel_bandgap(sel_bandgap),
  .sel_ground(sel_ground), .differential(differential), .pos_channel(pos_channel),
  .neg_channel(neg_channel), .gain(gain));

// file: tb/tb_adc_input_reference_select.sv
// Self-checking bench of the converter selection register block.
`timescale 1ns/1ps
`include "acs_regs.vh"
module tb_adc_input_reference_select;
  localparam logic [1:0] OK = `ACS_RESP_OKAY;
  localparam logic [1:0] ER = `ACS_RESP_SLVERR;
  logic        aclk, aresetn, core_done, conv_start, conv_busy, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, internal_ref_enable, code_valid;
  logic        single_ended, sel_bandgap, sel_ground, differential;
  logic        cv_en, cmp_en;
  logic [2:0]  presc;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, se_channel, pos_channel, neg_channel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reference_select, gain;
  logic [7:0]  trigger_in, dly;
  logic [9:0]  core_result, result;
  logic [26:0] row;
  int          fail_count, checked, i;
  // Rows: code, reference, {valid, single, bandgap, ground, diff}, channel, pos, neg, gain.
  // Gain codes only ride with the higher internal reference.
  // No external voltage is modelled on the reference pin, so internal references are free.
  localparam logic [26:0] ROWS [20] = '{
    {6'h00, 2'h0, 5'h18, 14'h0000}, {6'h07, 2'h1, 5'h18, 14'h1C00},
    {6'h20, 2'h2, 5'h18, 14'h2000}, {6'h27, 2'h3, 5'h18, 14'h3C00},
    {6'h1E, 2'h2, 5'h14, 14'h0000}, {6'h1F, 2'h0, 5'h12, 14'h0000},
    {6'h08, 2'h3, 5'h11, 14'h0001}, {6'h09, 2'h3, 5'h11, 14'h0041},
    {6'h0A, 2'h3, 5'h11, 14'h0002}, {6'h0B, 2'h3, 5'h11, 14'h0042},
    {6'h0C, 2'h3, 5'h11, 14'h0089}, {6'h0D, 2'h3, 5'h11, 14'h00C9},
    {6'h0E, 2'h3, 5'h11, 14'h008A}, {6'h0F, 2'h3, 5'h11, 14'h00CA},
    {6'h10, 2'h1, 5'h11, 14'h0004}, {6'h17, 2'h0, 5'h11, 14'h01C4},
    {6'h18, 2'h3, 5'h11, 14'h0008}, {6'h1D, 2'h1, 5'h11, 14'h0148},
    {6'h28, 2'h0, 5'h00, 14'h0000}, {6'h3F, 2'h0, 5'h00, 14'h0000}};
  localparam logic [7:0] IDX [7] = '{`ACS_IDX_DATA_LOW, `ACS_IDX_DATA_HIGH, `ACS_IDX_CTRL_A,
    `ACS_IDX_CTRL_B, `ACS_IDX_INPUT_SEL, `ACS_IDX_INT_STATUS, `ACS_IDX_INT_MASK};

  acs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trigger_in(trigger_in),
    .core_done(core_done), .core_result(core_result), .conv_start(conv_start),
    .conv_busy(conv_busy), .converter_enable(cv_en), .prescaler_select(presc),
    .comparator_mux_enable(cmp_en), .reference_select(reference_select),
    .internal_ref_enable(internal_ref_enable), .code_valid(code_valid),
    .single_ended(single_ended), .se_channel(se_channel), .sel_bandgap(sel_bandgap),
    .sel_ground(sel_ground), .differential(differential), .pos_channel(pos_channel),
    .neg_channel(neg_channel), .gain(gain), .irq(irq));
  acs_core_model u_core (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
    .dly(dly), .result(result), .core_done(core_done), .core_result(core_result));

  // ------
  // Tasks
  // ------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task axw(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
    // One idle edge keeps the next call from reassigning the ready in this time step.
    @(posedge aclk);
  endtask
  task axr(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] er);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, {24'h000000, ex});
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  task idle;
    while (conv_busy !== 1'h0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task test_done;
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------
  // Stimulus
  // ------
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (6000) @(posedge aclk);
    fail_count++;
    test_done;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, trigger_in, result} = 74'h0;
    s_axi_wstrb = 4'hF;
    dly = 8'h1E;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({single_ended, code_valid, irq}, 3'h6);
    for (i = 0; i < 7; i++) axr(IDX[i], 8'h00, OK);
    for (i = 0; i < 20; i++) begin
      row = ROWS[i];
      axw(`ACS_IDX_CTRL_B, {4'h0, row[26], 3'h0}, OK);
      axw(`ACS_IDX_INPUT_SEL, {row[20:19], 1'h0, row[25:21]}, OK);
      repeat (2) @(posedge aclk);
      chk({reference_select, internal_ref_enable}, {row[20:19], row[20]});
      chk({code_valid, single_ended, sel_bandgap, sel_ground, differential}, row[18:14]);
      if (row[17]) chk(se_channel, row[13:10]);
      if (row[14]) chk({pos_channel, neg_channel, gain}, row[9:0]);
      axr(`ACS_IDX_INPUT_SEL, {row[20:19], 1'h0, row[25:21]}, OK);
    end
    // A stalled master must find the write response held.
    s_axi_awaddr <= {2'h0, `ACS_IDX_INT_MASK, 2'h0};
    s_axi_wdata <= 32'h00000000;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    repeat (4) @(posedge aclk);
    chk(s_axi_bvalid, 1'h1);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    axw(`ACS_IDX_CTRL_B, 8'hFF, OK);
    chk(cmp_en, 1'h1);
    axr(`ACS_IDX_CTRL_B, 8'h4F, OK);
    axw(`ACS_IDX_CTRL_B, 8'h00, OK);
    axw(8'h7D, 8'h55, ER);
    axr(8'h7D, 8'h00, ER);
    axw(`ACS_IDX_INT_MASK, 8'h01, OK);
    // A write with the low byte lane off must leave the register alone.
    s_axi_wstrb <= 4'hE;
    axw(`ACS_IDX_INT_MASK, 8'h03, OK);
    s_axi_wstrb <= 4'hF;
    axr(`ACS_IDX_INT_MASK, 8'h01, OK);
    axw(`ACS_IDX_INPUT_SEL, 8'h41, OK);
    result <= 10'h270;
    // Enable first: a start written together with the enable is ignored by this design.
    axw(`ACS_IDX_CTRL_A, 8'h87, OK);
    chk({cv_en, presc}, 4'hF);
    axw(`ACS_IDX_CTRL_A, 8'hC0, OK);
    axw(`ACS_IDX_INPUT_SEL, 8'hC5, OK);
    chk({conv_busy, reference_select, se_channel}, {1'h1, 2'h1, 4'h1});
    idle;
    chk({reference_select, se_channel}, {2'h3, 4'h5});
    axr(`ACS_IDX_DATA_LOW, 8'h70, OK);
    axr(`ACS_IDX_DATA_HIGH, 8'h02, OK);
    axr(`ACS_IDX_CTRL_A, 8'h90, OK);
    chk(irq, 1'h1);
    result <= 10'h155;
    axw(`ACS_IDX_CTRL_A, 8'hC0, OK);
    axw(`ACS_IDX_INPUT_SEL, 8'hE5, OK);
    axr(`ACS_IDX_DATA_HIGH, 8'h9C, OK);
    axr(`ACS_IDX_DATA_LOW, 8'h00, OK);
    axr(`ACS_IDX_CTRL_A, 8'hD0, OK);
    idle;
    axr(`ACS_IDX_DATA_HIGH, 8'h55, OK);
    axr(`ACS_IDX_DATA_LOW, 8'h40, OK);
    axw(`ACS_IDX_CTRL_A, 8'h90, OK);
    axr(`ACS_IDX_CTRL_A, 8'h80, OK);
    axw(`ACS_IDX_INT_MASK, 8'h00, OK);
    chk(irq, 1'h0);
    axr(`ACS_IDX_INT_STATUS, 8'h01, OK);
    axw(`ACS_IDX_INT_STATUS, 8'h01, OK);
    axr(`ACS_IDX_INT_STATUS, 8'h00, OK);
    dly <= 8'h03;
    axw(`ACS_IDX_CTRL_B, 8'h02, OK);
    axw(`ACS_IDX_CTRL_A, 8'hA0, OK);
    trigger_in <= 8'h02;
    repeat (4) @(posedge aclk);
    chk(conv_busy, 1'h0);
    trigger_in <= 8'h06;
    while (conv_start !== 1'h1) @(posedge aclk);
    @(posedge aclk);
    idle;
    axr(`ACS_IDX_INT_STATUS, 8'h03, OK);
    test_done;
  end
endmodule // tb_adc_input_reference_select
